// [sgm_motion.sv]
// Two-gauge stepper motion controller with per-gauge microstep sequencers.
// Assumes target commands come from logic on ref_clk; coil outputs feed
// the H-bridge drivers directly.
`timescale 1ns/1ps
`default_nettype none
`include "sgm_consts.svh"

module sgm_motion #(
    // Clock cycles per table time unit; shorten for simulation
    parameter int TB_CLKS = `SGM_CLK_HZ / `SGM_TBASE_HZ
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Target commands, one per gauge
    input wire logic [`SGM_NGAUGE-1:0][`SGM_POS_W-1:0] tgt_pos,
    input wire logic [`SGM_NGAUGE-1:0] tgt_load,
    // Motion status
    output logic [`SGM_NGAUGE-1:0] moving,
    output logic [`SGM_NGAUGE-1:0][`SGM_POS_W-1:0] cur_pos,
    output logic [`SGM_NGAUGE-1:0][`SGM_IDX_W-1:0] ustep_idx,
    // Coil drive
    output logic [`SGM_NGAUGE-1:0][7:0] sin_mag,
    output logic [`SGM_NGAUGE-1:0] sin_neg,
    output logic [`SGM_NGAUGE-1:0][7:0] cos_mag,
    output logic [`SGM_NGAUGE-1:0] cos_neg
);
    import sgm_pkg::*;

    // Shortest interval, in time units, that keeps under maximum velocity
    localparam longint TMIN = (`SGM_TBASE_HZ + `SGM_VMAX - 1) / `SGM_VMAX;

    // Floor square root by the bitwise method
    function automatic longint sgm_isqrt(input longint v);
        longint r;
        longint b;
        longint x;
        r = 0;
        x = v;
        b = longint'(1) <<< 62;
        while (b > x) begin
            b = b >>> 2;
        end
        while (b != 0) begin
            if (x >= r + b) begin
                x = x - (r + b);
                r = (r >>> 1) + b;
            end else begin
                r = r >>> 1;
            end
            b = b >>> 2;
        end
        return r;
    endfunction

    // Distance covered in t time units reaches one step
    function automatic bit sgm_reach(input longint x, input longint t);
        longint lhs;
        longint rhs;
        lhs = 2 * longint'(`SGM_TBASE_HZ) * x * t + longint'(`SGM_VSCALE) * `SGM_ACCEL * t * t;
        rhs = 2 * longint'(`SGM_VSCALE) * `SGM_TBASE_HZ * `SGM_TBASE_HZ;
        return lhs >= rhs;
    endfunction

    // Ramp table at elaboration; velocity held in milli-steps per second
    function automatic sgm_ramp_t sgm_ramp_build();
        sgm_ramp_t r;
        longint x;
        longint q;
        longint t;
        x = 0;
        r[0] = '0;
        for (int n = 1; n < `SGM_RAMP_LEN; n++) begin
            q = x * x + 2 * longint'(`SGM_ACCEL) * `SGM_VSCALE * `SGM_VSCALE;
            t = (sgm_isqrt(q) - x) * `SGM_TBASE_HZ;
            t = (t + longint'(`SGM_VSCALE) * `SGM_ACCEL - 1) / (longint'(`SGM_VSCALE) * `SGM_ACCEL);
            // Exact ceiling despite the floored root
            while (!sgm_reach(x, t)) begin
                t = t + 1;
            end
            while (t > 1 && sgm_reach(x, t - 1)) begin
                t = t - 1;
            end
            if (t <= TMIN) begin
                t = TMIN;
            end else begin
                x = 2 * longint'(`SGM_VSCALE) * `SGM_TBASE_HZ / t - x;
            end
            r[n] = `SGM_RAMP_W'(t);
        end
        return r;
    endfunction

    localparam sgm_ramp_t RAMP = sgm_ramp_build();

    sgm_motion_st_t s_q;
    sgm_motion_st_t s_d;

    // Interval in clock cycles for a table index
    function automatic logic [`SGM_CNT_W-1:0] sgm_load(input logic [`SGM_N_W-1:0] n);
        return `SGM_CNT_W'(int'(RAMP[n]) * TB_CLKS);
    endfunction

    always_comb begin
        sgm_gauge_t g;
        sgm_gauge_t ng;
        logic [`SGM_POS_W-1:0] pos_nx;
        logic signed [`SGM_POS_W:0] diff;
        logic signed [`SGM_POS_W:0] fwd;
        logic signed [`SGM_POS_W:0] n_s;
        logic at_max;
        g = '0;
        ng = '0;
        pos_nx = '0;
        diff = '0;
        fwd = '0;
        n_s = '0;
        at_max = 1'b0;
        s_d = s_q;
        for (int i = 0; i < `SGM_NGAUGE; i++) begin
            g = s_q.g[i];
            ng = g;
            ng.step_cw = 1'b0;
            ng.step_ccw = 1'b0;
            if (tgt_load[i]) begin
                ng.tgt = tgt_pos[i];
            end
            unique case (g.state)
                SGM_IDLE: begin
                    // Stopped: no index until target differs from position
                    if (ng.tgt != g.pos) begin
                        ng.dir = ng.tgt > g.pos;
                        ng.n = `SGM_N_W'(1);
                        ng.cnt = sgm_load(`SGM_N_W'(1));
                        ng.state = SGM_ACCEL;
                        ng.busy = 1'b1;
                    end
                end
                SGM_ACCEL, SGM_CRUISE, SGM_DECEL: begin
                    if (g.cnt > `SGM_CNT_W'(1)) begin
                        ng.cnt = g.cnt - `SGM_CNT_W'(1);
                    end else begin
                        pos_nx = g.dir ? g.pos + `SGM_POS_W'(1) : g.pos - `SGM_POS_W'(1);
                        ng.pos = pos_nx;
                        ng.step_cw = g.dir;
                        ng.step_ccw = !g.dir;
                        diff = $signed({1'b0, ng.tgt}) - $signed({1'b0, pos_nx});
                        fwd = g.dir ? diff : -diff;
                        n_s = $signed({{(`SGM_POS_W + 1 - `SGM_N_W){1'b0}}, g.n});
                        at_max = (RAMP[g.n] <= `SGM_RAMP_W'(TMIN)) ||
                                 (g.n == `SGM_N_W'(`SGM_RAMP_LEN - 1));
                        if (fwd == '0 || (fwd < 0 && g.n <= `SGM_N_W'(1))) begin
                            // Arrived, or slow enough to turn round from rest
                            ng.state = SGM_IDLE;
                            ng.busy = 1'b0;
                            ng.n = '0;
                            ng.cnt = '0;
                        end else begin
                            if (fwd > n_s && !at_max) begin
                                ng.n = g.n + `SGM_N_W'(1);
                                ng.state = SGM_ACCEL;
                            end else if (fwd > n_s) begin
                                ng.state = SGM_CRUISE;
                            end else begin
                                // Index is the stopping distance; step back down
                                ng.n = (g.n > `SGM_N_W'(1)) ? g.n - `SGM_N_W'(1) : `SGM_N_W'(1);
                                ng.state = SGM_DECEL;
                            end
                            ng.cnt = sgm_load(ng.n);
                        end
                    end
                end
            endcase
            s_d.g[i] = ng;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            for (int i = 0; i < `SGM_NGAUGE; i++) begin
                s_q.g[i] <= '{state: SGM_IDLE, dir: 1'b0, n: '0, cnt: '0, pos: `SGM_RESET_POS,
                              tgt: `SGM_RESET_POS, step_cw: 1'b0, step_ccw: 1'b0, busy: 1'b0};
            end
        end else begin
            s_q <= s_d;
        end
    end

    for (genvar gi = 0; gi < `SGM_NGAUGE; gi++) begin : g_gauge
        assign moving[gi] = s_q.g[gi].busy;
        assign cur_pos[gi] = s_q.g[gi].pos;

        sgm_microstep u_ustep (
            .ref_clk (ref_clk),
            .rstn (rstn),
            .step_cw (s_q.g[gi].step_cw),
            .step_ccw (s_q.g[gi].step_ccw),
            .idx (ustep_idx[gi]),
            .sin_mag (sin_mag[gi]),
            .sin_neg (sin_neg[gi]),
            .cos_mag (cos_mag[gi]),
            .cos_neg (cos_neg[gi])
        );
    end

endmodule // sgm_motion

`default_nettype wire

// [sgm_consts.svh]
// Named constants for the dual gauge motion controller.
// Assumes inclusion by bare name from the package and design files.
`ifndef SGM_CONSTS_SVH
`define SGM_CONSTS_SVH

`define SGM_NGAUGE 2
`define SGM_POS_W 12
`define SGM_RESET_POS 12'h000
`define SGM_NSTEP 24
`define SGM_DEG_PER_REV 2
`define SGM_IDX_W 5
`define SGM_QTR 6
`define SGM_HALF 12
`define SGM_SIN_NEG_LO 13
`define SGM_COS_NEG_LO 7
`define SGM_COS_NEG_HI 17
`define SGM_MAG_0 8'h00
`define SGM_MAG_1 8'h42
`define SGM_MAG_2 8'h80
`define SGM_MAG_3 8'hb5
`define SGM_MAG_4 8'hde
`define SGM_MAG_5 8'hf7
`define SGM_MAG_6 8'hff
`define SGM_CLK_HZ 20000000
`define SGM_TBASE_HZ 1000000
`define SGM_VMAX 4800
`define SGM_ACCEL 54000
`define SGM_VSCALE 1000
`define SGM_RAMP_LEN 256
`define SGM_RAMP_W 14
`define SGM_N_W 8
`define SGM_CNT_W 18

`endif

// [sgm_pkg.sv]
// Types shared by the motion controller and the microstep sequencer.
// Assumes sgm_consts.svh is on the include path.
`include "sgm_consts.svh"

package sgm_pkg;

    typedef enum logic [1:0] {
        SGM_IDLE = 2'b00,
        SGM_ACCEL = 2'b01,
        SGM_CRUISE = 2'b10,
        SGM_DECEL = 2'b11
    } sgm_state_t;

    typedef logic [`SGM_RAMP_W-1:0] sgm_ramp_t [0:`SGM_RAMP_LEN-1];

    typedef struct packed {
        sgm_state_t state;
        logic dir;
        logic [`SGM_N_W-1:0] n;
        logic [`SGM_CNT_W-1:0] cnt;
        logic [`SGM_POS_W-1:0] pos;
        logic [`SGM_POS_W-1:0] tgt;
        logic step_cw;
        logic step_ccw;
        logic busy;
    } sgm_gauge_t;

    typedef struct packed {
        sgm_gauge_t [`SGM_NGAUGE-1:0] g;
    } sgm_motion_st_t;

    typedef struct packed {
        logic [`SGM_IDX_W-1:0] idx;
        logic [7:0] sin_mag;
        logic sin_neg;
        logic [7:0] cos_mag;
        logic cos_neg;
    } sgm_ustep_st_t;

endpackage

// [sgm_microstep.sv]
// Microstep sequencer for one gauge: index pulses in, coil setting out.
// Assumes step pulses come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sgm_consts.svh"

module sgm_microstep (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Index commands
    input wire logic step_cw,
    input wire logic step_ccw,
    // Coil setting
    output logic [`SGM_IDX_W-1:0] idx,
    output logic [7:0] sin_mag,
    output logic sin_neg,
    output logic [7:0] cos_mag,
    output logic cos_neg
);
    import sgm_pkg::*;

    sgm_ustep_st_t s_q;
    sgm_ustep_st_t s_d;

    // Quarter wave magnitude for a step 0..23
    function automatic logic [7:0] sgm_mag(input logic [`SGM_IDX_W-1:0] i);
        logic [`SGM_IDX_W-1:0] q;
        q = (i <= `SGM_IDX_W'(`SGM_QTR)) ? i :
            (i <= `SGM_IDX_W'(`SGM_HALF)) ? `SGM_IDX_W'(`SGM_HALF) - i :
            (i <= `SGM_IDX_W'(`SGM_HALF + `SGM_QTR)) ? i - `SGM_IDX_W'(`SGM_HALF) :
            `SGM_IDX_W'(`SGM_NSTEP) - i;
        unique case (q)
            5'h0: sgm_mag = `SGM_MAG_0;
            5'h1: sgm_mag = `SGM_MAG_1;
            5'h2: sgm_mag = `SGM_MAG_2;
            5'h3: sgm_mag = `SGM_MAG_3;
            5'h4: sgm_mag = `SGM_MAG_4;
            5'h5: sgm_mag = `SGM_MAG_5;
            default: sgm_mag = `SGM_MAG_6;
        endcase
    endfunction

    always_comb begin
        logic [`SGM_IDX_W-1:0] ni;
        logic [`SGM_IDX_W-1:0] ci;
        ni = s_q.idx;
        ci = '0;
        s_d = s_q;
        if (step_cw) begin
            ni = (s_q.idx == `SGM_IDX_W'(`SGM_NSTEP - 1)) ? '0 : s_q.idx + 5'h1;
        end else if (step_ccw) begin
            ni = (s_q.idx == '0) ? `SGM_IDX_W'(`SGM_NSTEP - 1) : s_q.idx - 5'h1;
        end
        // Cosine leads sine by a quarter cycle
        ci = (ni >= `SGM_IDX_W'(`SGM_NSTEP - `SGM_QTR)) ? ni - `SGM_IDX_W'(`SGM_NSTEP - `SGM_QTR) :
             ni + `SGM_IDX_W'(`SGM_QTR);
        s_d.idx = ni;
        s_d.sin_mag = sgm_mag(ni);
        s_d.cos_mag = sgm_mag(ci);
        s_d.sin_neg = ni >= `SGM_IDX_W'(`SGM_SIN_NEG_LO);
        s_d.cos_neg = (ni >= `SGM_IDX_W'(`SGM_COS_NEG_LO)) && (ni <= `SGM_IDX_W'(`SGM_COS_NEG_HI));
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_q <= '{idx: '0, sin_mag: `SGM_MAG_0, sin_neg: 1'b0, cos_mag: `SGM_MAG_6, cos_neg: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign idx = s_q.idx;
    assign sin_mag = s_q.sin_mag;
    assign sin_neg = s_q.sin_neg;
    assign cos_mag = s_q.cos_mag;
    assign cos_neg = s_q.cos_neg;

endmodule // sgm_microstep

`default_nettype wire

// [sgm_motion_assertions.sv]
// Port checker for the two-gauge motion controller, bound onto sgm_motion.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "sgm_consts.svh"
module sgm_motion_assertions #(
    parameter int TB_CLKS = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Targets
    input wire logic [1:0][11:0] tgt_pos,
    input wire logic [1:0] tgt_load,
    // Status and coils
    input wire logic [1:0] moving,
    input wire logic [1:0][11:0] cur_pos,
    input wire logic [1:0][4:0] ustep_idx,
    input wire logic [1:0][7:0] sin_mag,
    input wire logic [1:0] sin_neg,
    input wire logic [1:0][7:0] cos_mag,
    input wire logic [1:0] cos_neg
);
    // Maximum-velocity spacing is the shortest legal one
    localparam int MIN_GAP = 209 * TB_CLKS - 1;
    localparam logic [7:0] MAGS [0:6] = '{8'h00, 8'h42, 8'h80, 8'hb5, 8'hde, 8'hf7, 8'hff};
    function automatic logic [7:0] mag(input logic [4:0] i);
        int q;
        q = i % 12;
        return MAGS[(q > 6) ? 12 - q : q];
    endfunction
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    for (genvar g = 0; g < 2; g++) begin : gc
        logic [15:0] cnt_q;
        // Saturates so a long idle spell cannot wrap to a small value
        always_ff @(posedge ref_clk) begin
            cnt_q <= (!rstn || $changed(cur_pos[g])) ? 16'h0 : cnt_q + {15'h0, ~&cnt_q};
        end
        a_pos_unit: assert property ($past(rstn) && $changed(cur_pos[g]) |->
            12'(cur_pos[g] - $past(cur_pos[g])) inside {12'h001, 12'hfff}) else $error("position jump");
        a_step_gap: assert property ($past(rstn) && $changed(cur_pos[g]) |->
            cnt_q >= MIN_GAP) else $error("steps too close");
        a_idx_range: assert property (ustep_idx[g] < 5'h18) else $error("index out of range");
        a_idx_follow: assert property ($past(rstn) && cur_pos[g] == $past(cur_pos[g]) + 12'h001 |=>
            ustep_idx[g] == (($past(ustep_idx[g]) == 5'h17) ? 5'h00 : $past(ustep_idx[g]) + 5'h01))
            else $error("index did not follow");
        a_idx_back: assert property ($past(rstn) && cur_pos[g] == $past(cur_pos[g]) - 12'h001 |=>
            ustep_idx[g] == (($past(ustep_idx[g]) == 5'h00) ? 5'h17 : $past(ustep_idx[g]) - 5'h01))
            else $error("index did not follow back");
        a_sin_table: assert property (sin_mag[g] == mag(ustep_idx[g]) &&
            sin_neg[g] == (ustep_idx[g] >= 5'h0d)) else $error("sine coil wrong");
        a_cos_table: assert property (cos_mag[g] == mag(ustep_idx[g] + 5'h06) &&
            cos_neg[g] == (ustep_idx[g] inside {[5'h07:5'h11]})) else $error("cosine coil wrong");
        a_idle_quiet: assert property (!moving[g] |=> $stable(cur_pos[g])) else $error("idle gauge stepped");
        a_start_move: assert property (tgt_load[g] && !moving[g] && tgt_pos[g] != cur_pos[g] |->
            ##[1:2] moving[g]) else $error("move did not start");
    end
endmodule // sgm_motion_assertions

bind sgm_motion sgm_motion_assertions #(.TB_CLKS(TB_CLKS)) sgm_motion_assertions_i (.ref_clk(ref_clk),
    .rstn(rstn), .tgt_pos(tgt_pos), .tgt_load(tgt_load), .moving(moving), .cur_pos(cur_pos),
    .ustep_idx(ustep_idx), .sin_mag(sin_mag), .sin_neg(sin_neg), .cos_mag(cos_mag), .cos_neg(cos_neg));
`default_nettype wire

// [sgm_coil_model.sv]
// H-bridge coil pair model: turns coil currents back into a rotor phase.
// Assumes coil values are registered outputs of one gauge.
`timescale 1ns/1ps
`default_nettype none
module sgm_coil_model (
    // Coil drive
    input wire logic [7:0] sin_mag,
    input wire logic sin_neg,
    input wire logic [7:0] cos_mag,
    input wire logic cos_neg,
    // Rotor phase, 5'h1f when no phase fits
    output logic [4:0] ang
);
    localparam logic [7:0] MAGS [0:6] = '{8'h00, 8'h42, 8'h80, 8'hb5, 8'hde, 8'hf7, 8'hff};
    function automatic logic [7:0] mag(input int i);
        int q;
        q = i % 12;
        return MAGS[(q > 6) ? 12 - q : q];
    endfunction
    always_comb begin
        ang = 5'h1f;
        for (int i = 0; i < 24; i++) begin
            if (sin_mag === mag(i) && sin_neg === (i >= 13) && cos_mag === mag(i + 6)
                && cos_neg === (i >= 7 && i <= 17)) begin
                ang = 5'(i);
            end
        end
    end
endmodule // sgm_coil_model
`default_nettype wire

// [stepper_gauge_motion_control_tb.sv]
// Self-checking bench for the two-gauge motion controller.
// Assumes the design, coil model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sgm_consts.svh"
module stepper_gauge_motion_control_tb;
    localparam int TB = 1;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [1:0][11:0] tgt_pos = '0;
    logic [1:0] tgt_load = '0;
    logic [1:0] moving, sin_neg, cos_neg, pm;
    logic [1:0][11:0] cur_pos, pp;
    logic [1:0][4:0] ustep_idx;
    wire logic [1:0][4:0] ang;
    logic [1:0][7:0] sin_mag, cos_mag;
    logic [31:0] seed = 32'h6;
    logic [11:0] tg [2];
    int error_cnt = 0;
    int compares = 0;
    int rt [0:40];
    int n [2];
    int gap [2];
    int d;
    always #25 ref_clk = ~ref_clk;
    sgm_motion #(.TB_CLKS(TB)) sgm_motion_i (.ref_clk(ref_clk), .rstn(rstn), .tgt_pos(tgt_pos),
        .tgt_load(tgt_load), .moving(moving), .cur_pos(cur_pos), .ustep_idx(ustep_idx),
        .sin_mag(sin_mag), .sin_neg(sin_neg), .cos_mag(cos_mag), .cos_neg(cos_neg));
    for (genvar g = 0; g < 2; g++) begin : gm
        sgm_coil_model sgm_coil_model_i (.sin_mag(sin_mag[g]), .sin_neg(sin_neg[g]),
            .cos_mag(cos_mag[g]), .cos_neg(cos_neg[g]), .ang(ang[g]));
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Constant-acceleration intervals in microseconds, rounded up
    function automatic void mk_ramp();
        real v, t;
        v = 0.0;
        for (int i = 1; i <= 40; i++) begin
            t = (-v + $sqrt(v * v + 2.0 * `SGM_ACCEL)) / `SGM_ACCEL;
            rt[i] = int'($ceil(t * 1.0e6));
            v = 2.0e6 / rt[i] - v;
        end
    endfunction
    task automatic chk(input logic [11:0] a, input logic [11:0] e, input string m);
        compares++;
        if (a !== e) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, a, e);
        end
    endtask
    // Small slack: the design may round the table differently
    task automatic chk_gap(input int a, input int e);
        compares++;
        if (a < e - 3 || a > e + 3) begin
            error_cnt++;
            $display("MISMATCH %0t step gap %0d exp %0d", $time, a, e);
        end
    endtask
    task automatic end_of_test();
        $display("error_cnt %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic ld(input logic [11:0] t0, input logic [11:0] t1);
        logic [1:0] go;
        #1;
        go = {t1 !== cur_pos[1], t0 !== cur_pos[0]};
        @(posedge ref_clk);
        tgt_pos <= {t1, t0};
        tgt_load <= 2'h3;
        tg[0] = t0;
        tg[1] = t1;
        @(posedge ref_clk);
        tgt_load <= 2'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        chk({10'h0, moving}, {10'h0, go}, "start");
        for (int k = 0; k < 60000 && moving !== 2'h0; k++) @(posedge ref_clk);
        // A move that never ends shows up here as a mismatch
        chk({10'h0, moving}, 12'h000, "stop");
        chk(cur_pos[0], t0, "end pos 0");
        chk(cur_pos[1], t1, "end pos 1");
    endtask
    always @(posedge ref_clk) begin
        for (int g = 0; g < 2; g++) begin
            if (rstn !== 1'b1) begin
                pp[g] = cur_pos[g];
            end else begin
                gap[g]++;
                if (moving[g] === 1'b1 && pm[g] !== 1'b1) begin
                    n[g] = 1;
                    gap[g] = 0;
                end
                if (cur_pos[g] !== pp[g]) begin
                    chk(cur_pos[g], (tg[g] > pp[g]) ? pp[g] + 12'h001 : pp[g] - 12'h001, "pos");
                    chk_gap(gap[g], rt[n[g]] * TB);
                    d = (tg[g] > cur_pos[g]) ? tg[g] - cur_pos[g] : cur_pos[g] - tg[g];
                    chk({11'h0, moving[g]}, 12'(d != 0), "moving");
                    // Expected table index
                    if (d > n[g]) n[g]++;
                    else if (n[g] > 1) n[g]--;
                    gap[g] = 0;
                end else begin
                    chk({7'h0, ustep_idx[g]}, 12'(cur_pos[g] % 24), "idx");
                    chk({7'h0, ang[g]}, 12'(cur_pos[g] % 24), "coil");
                end
                pp[g] = cur_pos[g];
                pm[g] = moving[g];
            end
        end
    end
    initial begin
        repeat (95000) @(posedge ref_clk);
        error_cnt++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        mk_ramp();
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        // Gauge 0 wraps the index upward, gauge 1 stops short
        ld(12'h018, 12'h003);
        // Downward wrap on gauge 0; gauge 1 reloaded with its own position
        ld(12'h014 + 12'(xs() % 3), 12'h003);
        ld(12'h016, 12'(xs() % 3));
        end_of_test();
    end
endmodule // stepper_gauge_motion_control_tb
`default_nettype wire
